/* File: pvam_monitor.sv */
// Process value alarm evaluation, error detection and error response
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Process low alarms when value at or below setpoint
// - Process high alarms when value at or above setpoint
// - Signed deviation band alarms beyond setpoint plus band
// - Window band alarms outside symmetric band around setpoint
// - Setpoints and alarm settings writable only when enabled
// - Tuning uses main setpoint; active setpoint main unless auxiliary
// - Out of range or open input flashes error
// - Range error keeps reverse drive relay energised
// - Temperature sensor break follows valve strategy setting
// - Open linear input shows zero level scaled value
// - Open RTD compensating lead raises no error
// - Any value error aborts running tuning
// - Value error holds profile and lights lamp steadily
// - Under-range evaluates alarm at range minimum
// - Over-range evaluates alarm at range maximum
// - Open input over-range for temperature, under for linear
// - Beyond linearisation table flags sensor open message
// - Temperature sensor break opens loop, valve per strategy
// ----------------------------------------------------------------------------
`timescale 1ns/1ps

module pvam_monitor
   import pvam_pkg::*;
#(
   parameter int FLASH_DIV = FLASH_CYCLES
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Front end (asynchronous to this clock)
   input  wire logic signed [15:0]      rawValue,
   input  wire logic                    sensorOpen,
   input  wire logic                    leadOpen,
   input  wire logic                    tableExceeded,
   // Configuration from the settings store
   input  wire pvam_pkg::pvam_input_t   inputType,
   input  wire logic signed [15:0]      rangeMin,
   input  wire logic signed [15:0]      rangeMax,
   input  wire logic signed [15:0]      zeroLevelValue,
   input  wire pvam_pkg::pvam_brk_t     brkStrategy,
   input  wire logic                    auxModeEn,
   input  wire logic                    auxSelect,
   input  wire logic                    adjustEn,
   input  wire logic                    tuningRunning,
   input  wire logic                    profileRunning,
   input  wire logic                    loopRaise,
   input  wire logic                    loopLower,
   // Register port
   input  wire logic [3:0]              regAddr,
   input  wire logic [15:0]             regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic [15:0]                  regRdata,
   // Responses
   output logic signed [15:0]           processValue,
   output logic signed [15:0]           activeSetpoint,
   output logic signed [15:0]           tuneSetpoint,
   output logic                         errorFlash,
   output logic                         sensorOpenMessage,
   output logic                         underRange,
   output logic                         overRange,
   output logic                         openSensor,
   output logic                         alarm,
   output logic                         fwdDriveRelay,
   output logic                         reverseDriveRelay,
   output logic                         openLoop,
   output logic                         tuneAbort,
   output logic                         profileHold,
   output logic                         profileHoldLamp,
   output logic                         irq
);

   // --------------------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------------------
   localparam logic [3:0] A_ALMTYPE = 4'h0;
   localparam logic [3:0] A_ALMSP   = 4'h1;
   localparam logic [3:0] A_DEVBAND = 4'h2;
   localparam logic [3:0] A_WINBAND = 4'h3;
   localparam logic [3:0] A_CTRLSP  = 4'h4;
   localparam logic [3:0] A_AUXSP   = 4'h5;
   localparam logic [3:0] A_STATUS  = 4'h6;
   localparam logic [3:0] A_MASK    = 4'h7;
   localparam logic [3:0] A_PV      = 4'h8;

   // A divider below two cannot make a blink phase, so refuse it
   if (FLASH_DIV < 2) begin : gBadDiv
      $error("FLASH_DIV too small");
   end

   // Saturating clamp, used for both band settings
   function automatic logic signed [15:0] clampVal(
      input logic signed [15:0] v,
      input logic signed [15:0] lo,
      input logic signed [15:0] hi);
      clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clampVal

   // --------------------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------------------
   logic signed [15:0] rawS1_r, rawS2_r;
   logic [2:0]         flgS1_r, flgS2_r;

   // Two stages; stage one is read only by stage two
   always_ff @(posedge clk) begin
      if (rst) begin
         rawS1_r <= 16'sh0000;
         rawS2_r <= 16'sh0000;
         flgS1_r <= 3'h0;
         flgS2_r <= 3'h0;
      end else begin
         rawS1_r <= rawValue;
         rawS2_r <= rawS1_r;
         flgS1_r <= {tableExceeded, leadOpen, sensorOpen};
         flgS2_r <= flgS1_r;
      end
   end

   logic sOpen, sLead, sTable;
   assign sOpen  = flgS2_r[0];
   assign sLead  = flgS2_r[1];
   assign sTable = flgS2_r[2];

   // --------------------------------------------------------------------------
   // Settings registers
   // --------------------------------------------------------------------------
   pvam_alarm_t        almType_r;
   logic signed [15:0] almSp_r, devBand_r, winBand_r, ctrlSp_r, auxSp_r;
   logic [ST_W-1:0]    mask_r;
   logic               setptWr;

   // Operator writes to setpoints only with supervisory enable
   assign setptWr = regWr && adjustEn;

   always_ff @(posedge clk) begin
      if (rst) begin
         almType_r <= ALM_NONE;
         almSp_r   <= ALM_SP_LOW_DEF;
         devBand_r <= DEV_BAND_DEF;
         winBand_r <= WIN_BAND_DEF;
         ctrlSp_r  <= SP_DEF;
         auxSp_r   <= SP_DEF;
         mask_r    <= '0;
      end else begin
         if (setptWr && regAddr == A_ALMTYPE) begin
            almType_r <= pvam_alarm_t'(regWdata[2:0]);
            // Type change reloads its documented default setpoint
            if (regWdata[2:0] == 3'(ALM_PROC_HIGH))
               almSp_r <= ALM_SP_HIGH_DEF;
            else
               almSp_r <= ALM_SP_LOW_DEF;
         end else if (setptWr && regAddr == A_ALMSP) begin
            almSp_r <= regWdata;
         end else if (setptWr && regAddr == A_DEVBAND) begin
            devBand_r <= clampVal(regWdata, DEV_BAND_MIN,
                                  DEV_BAND_MAX);
         end else if (setptWr && regAddr == A_WINBAND) begin
            winBand_r <= clampVal(regWdata, WIN_BAND_MIN,
                                  WIN_BAND_MAX);
         end else if (setptWr && regAddr == A_CTRLSP) begin
            ctrlSp_r <= regWdata;
         end else if (setptWr && regAddr == A_AUXSP) begin
            auxSp_r <= regWdata;
         end
         // Mask is not an operator setpoint and is always writable
         if (regWr && regAddr == A_MASK) mask_r <= regWdata[ST_W-1:0];
      end
   end

   // --------------------------------------------------------------------------
   // Error classification (combinational, same cycle as inputs settle)
   // --------------------------------------------------------------------------
   logic isTemp, brkOpen, errUnder, errOver, errAny;
   assign isTemp  = (inputType != IN_LINEAR);
   // Lead-only open on an RTD is not a break; table overflow on a temperature input is
   assign brkOpen = sOpen || (isTemp && sTable);
   assign errUnder = (!brkOpen && rawS2_r < rangeMin)
                   || (brkOpen && !isTemp);
   assign errOver  = (!brkOpen && rawS2_r > rangeMax)
                   || (brkOpen && isTemp);
   assign errAny   = errUnder || errOver;

   // Value seen by alarm logic is pinned to the range end on an error
   logic signed [15:0] evalPv, dispPv;
   always_comb begin
      if (errUnder)      evalPv = rangeMin;
      else if (errOver)  evalPv = rangeMax;
      else               evalPv = rawS2_r;
      // Open linear input reads as the zero-signal scaled value
      if (brkOpen && !isTemp) dispPv = zeroLevelValue;
      else                    dispPv = rawS2_r;
   end

   // --------------------------------------------------------------------------
   // Alarm evaluation
   // --------------------------------------------------------------------------
   logic signed [17:0] spExt, devLim, winHi, winLo, pvExt;
   logic               almNow;
   always_comb begin
      spExt  = 18'(ctrlSp_r);
      pvExt  = 18'(evalPv);
      devLim = spExt + 18'(devBand_r);
      winHi  = spExt + 18'(winBand_r);
      winLo  = spExt - 18'(winBand_r);
      almNow = 1'b0;
      case (almType_r)
         ALM_PROC_LOW:  almNow = (evalPv <= almSp_r);
         ALM_PROC_HIGH: almNow = (evalPv >= almSp_r);
         ALM_DEV_BAND: begin
            if (devBand_r >= 0) almNow = (pvExt > devLim);
            else                almNow = (pvExt < devLim);
         end
         ALM_WIN_BAND:  almNow = (pvExt > winHi) || (pvExt < winLo);
         default:       almNow = 1'b0;
      endcase
   end

   // --------------------------------------------------------------------------
   // Flash timebase for the error message
   // --------------------------------------------------------------------------
   logic [31:0] flashCnt_r;
   logic        flashPh_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         flashCnt_r <= '0;
         flashPh_r  <= 1'b0;
      end else if (flashCnt_r == 32'(FLASH_DIV - 1)) begin
         flashCnt_r <= '0;
         flashPh_r  <= ~flashPh_r;
      end else begin
         flashCnt_r <= flashCnt_r + 32'd1;
      end
   end

   // --------------------------------------------------------------------------
   // Registered responses
   // --------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         processValue      <= 16'sh0000;
         activeSetpoint    <= SP_DEF;
         tuneSetpoint      <= SP_DEF;
         underRange        <= 1'b0;
         overRange         <= 1'b0;
         openSensor        <= 1'b0;
         alarm             <= 1'b0;
         errorFlash        <= 1'b0;
         sensorOpenMessage <= 1'b0;
      end else begin
         processValue      <= dispPv;
         // Auxiliary applies only when its mode is on and selected
         activeSetpoint    <= (auxModeEn && auxSelect) ? auxSp_r
                                                       : ctrlSp_r;
         tuneSetpoint      <= ctrlSp_r;
         underRange        <= errUnder;
         overRange         <= errOver;
         openSensor        <= brkOpen;
         alarm             <= almNow;
         errorFlash        <= (errAny || brkOpen) && flashPh_r;
         sensorOpenMessage <= brkOpen && isTemp && flashPh_r;
      end
   end

   // Valve drive: reverse relay pinned during range errors; a temperature
   // break overrides with the chosen strategy, open loop ignores control.
   always_ff @(posedge clk) begin
      if (rst) begin
         fwdDriveRelay     <= 1'b0;
         reverseDriveRelay <= 1'b0;
         openLoop          <= 1'b0;
      end else if (brkOpen && isTemp) begin
         openLoop          <= 1'b1;
         fwdDriveRelay     <= (brkStrategy == BRK_OPEN);
         reverseDriveRelay <= (brkStrategy == BRK_CLOSE);
      end else if (errAny) begin
         openLoop          <= 1'b0;
         fwdDriveRelay     <= 1'b0;
         reverseDriveRelay <= 1'b1;
      end else begin
         openLoop          <= 1'b0;
         fwdDriveRelay     <= loopRaise && !loopLower;
         reverseDriveRelay <= loopLower && !loopRaise;
      end
   end

   // Tuning abort held while an error stands, and profile hold with a steady lamp
   always_ff @(posedge clk) begin
      if (rst) begin
         tuneAbort       <= 1'b0;
         profileHold     <= 1'b0;
         profileHoldLamp <= 1'b0;
      end else begin
         tuneAbort       <= (errAny || brkOpen) && tuningRunning;
         profileHold     <= (errAny || brkOpen) && profileRunning;
         profileHoldLamp <= (errAny || brkOpen) && profileRunning;
      end
   end

   // --------------------------------------------------------------------------
   // Sticky status, mask, interrupt and read port
   // --------------------------------------------------------------------------
   logic [ST_W-1:0] status_r, stEvt;
   logic            stClr;
   assign stEvt = {almNow, brkOpen, errOver, errUnder};
   assign stClr = regRd && regAddr == A_STATUS;

   // Set wins over the read clear so no event is lost
   always_ff @(posedge clk) begin
      if (rst) status_r <= '0;
      else     status_r <= (stClr ? '0 : status_r) | stEvt;
   end

   always_ff @(posedge clk) begin
      if (rst) irq <= 1'b0;
      else     irq <= |(((stClr ? '0 : status_r) | stEvt) & mask_r);
   end

   // Read data valid in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         if (regAddr == A_ALMTYPE)      regRdata <= {13'h0000, almType_r};
         else if (regAddr == A_ALMSP)   regRdata <= almSp_r;
         else if (regAddr == A_DEVBAND) regRdata <= devBand_r;
         else if (regAddr == A_WINBAND) regRdata <= winBand_r;
         else if (regAddr == A_CTRLSP)  regRdata <= ctrlSp_r;
         else if (regAddr == A_AUXSP)   regRdata <= auxSp_r;
         else if (regAddr == A_STATUS)  regRdata <= {12'h000, status_r};
         else if (regAddr == A_MASK)    regRdata <= {12'h000, mask_r};
         else if (regAddr == A_PV)      regRdata <= dispPv;
         else                           regRdata <= 16'h0000;
      end else begin
         regRdata <= 16'h0000;
      end
   end

   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   lowAlarm_a: assert property (@(posedge clk) disable iff (rst)
      (almType_r == ALM_PROC_LOW && !errAny && rawS2_r <= almSp_r
       && $stable(almType_r)) |=> alarm)
      else $error("process low alarm missing");

   highAlarm_a: assert property (@(posedge clk) disable iff (rst)
      (almType_r == ALM_PROC_HIGH && !errAny && rawS2_r < almSp_r)
      |=> !alarm)
      else $error("process high alarm false");

   devBand_a: assert property (@(posedge clk) disable iff (rst)
      devBand_r >= DEV_BAND_MIN && devBand_r <= DEV_BAND_MAX)
      else $error("deviation band out of limits");

   winBand_a: assert property (@(posedge clk) disable iff (rst)
      winBand_r >= WIN_BAND_MIN && winBand_r <= WIN_BAND_MAX)
      else $error("window band out of limits");

   lockedSp_a: assert property (@(posedge clk) disable iff (rst)
      (!adjustEn) |=> $stable(ctrlSp_r) && $stable(auxSp_r))
      else $error("setpoint changed while locked");

   tuneSp_a: assert property (@(posedge clk) disable iff (rst)
      ##1 tuneSetpoint == $past(ctrlSp_r))
      else $error("tuning setpoint not main");

   revRelay_a: assert property (@(posedge clk) disable iff (rst)
      (errAny && !(brkOpen && isTemp)) |=> reverseDriveRelay
      && !fwdDriveRelay)
      else $error("reverse relay not held on error");

   tuneAbort_a: assert property (@(posedge clk) disable iff (rst)
      (errOver && tuningRunning) |=> tuneAbort)
      else $error("tuning not aborted on error");

   lampHold_a: assert property (@(posedge clk) disable iff (rst)
      (errUnder && profileRunning) [*2] |=> profileHoldLamp
      && $past(profileHoldLamp))
      else $error("profile lamp not steady on error");

   openClass_a: assert property (@(posedge clk) disable iff (rst)
      (sOpen && inputType == IN_LINEAR) |=> underRange && !overRange)
      else $error("linear open not under-range");

endmodule : pvam_monitor

/* File: pvam_pkg.sv */
// Package: constants and types for the process value alarm and error monitor
package pvam_pkg;

   localparam int PV_W = 16;                       // Signed process value width

   // -------------------------------------------------------------------------
   // Setpoint and band defaults and limits
   // -------------------------------------------------------------------------
   localparam logic signed [15:0] ALM_SP_LOW_DEF  = -16'sd200;
   localparam logic signed [15:0] ALM_SP_HIGH_DEF = 16'sd1300;
   localparam logic signed [15:0] DEV_BAND_MIN    = -16'sd999;
   localparam logic signed [15:0] DEV_BAND_MAX    = 16'sd999;
   localparam logic signed [15:0] DEV_BAND_DEF    = 16'sd3;
   localparam logic signed [15:0] WIN_BAND_MIN    = 16'sd3;
   localparam logic signed [15:0] WIN_BAND_MAX    = 16'sd999;
   localparam logic signed [15:0] WIN_BAND_DEF    = 16'sd3;
   localparam logic signed [15:0] SP_DEF          = -16'sd200;
   localparam logic signed [15:0] ZERO_LVL_DEF    = 16'sd0;

   // Flash blink divider: 250 ms half period at 40 MHz
   localparam int CLK_HZ        = 40_000_000;
   localparam int FLASH_MS      = 250;
   localparam int FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_MS;

   // Alarm types
   typedef enum logic [2:0] {
      ALM_NONE, ALM_PROC_LOW, ALM_PROC_HIGH, ALM_DEV_BAND, ALM_WIN_BAND
   } pvam_alarm_t;

   // Input families
   typedef enum logic [1:0] {
      IN_TC, IN_RTD, IN_LINEAR
   } pvam_input_t;

   // Sensor break valve strategy
   typedef enum logic [1:0] {
      BRK_HOLD, BRK_CLOSE, BRK_OPEN
   } pvam_brk_t;

   // Status bit positions
   localparam int ST_UNDER = 0;
   localparam int ST_OVER  = 1;
   localparam int ST_OPEN  = 2;
   localparam int ST_ALARM = 3;
   localparam int ST_W     = 4;

endpackage : pvam_pkg

/* File: pvam_front_end.sv */
// Behavioural sensor front end feeding the monitor
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Sensor front end model
// ---------------------------------------------------------------
module pvam_front_end (
   input  wire logic          clk,
   output logic signed [15:0] rawValue,
   output logic               sensorOpen,
   output logic               leadOpen,
   output logic               tableExceeded
);
   logic signed [15:0] valR;

   // Quiet, closed sensor at time zero
   initial begin
      valR = '0;
      rawValue = '0;
      sensorOpen = 1'b0;
      leadOpen = 1'b0;
      tableExceeded = 1'b0;
   end

   // An open sensor gives no usable reading, so the value churns
   always @(posedge clk) rawValue <= sensorOpen ? ~rawValue : valR;

   // Levels change just after an edge and then stand
   task automatic apply(input int v, input bit op, input bit ld,
                        input bit tb);
      @(posedge clk);
      valR <= 16'(v);
      sensorOpen <= op;
      leadOpen <= ld;
      tableExceeded <= tb;
   endtask : apply
endmodule : pvam_front_end

/* File: pvam_monitor_tb.sv */
// Self-checking bench for the process value alarm and error monitor
`timescale 1ns/1ps

module pvam_monitor_tb;
   import pvam_pkg::*;
   logic               clk, rst, auxModeEn, auxSelect, adjustEn;
   logic               tuningRunning, profileRunning, loopRaise, loopLower;
   logic               regWr, regRd, errorFlash, sensorOpenMessage, irq;
   logic               underRange, overRange, openSensor, alarm, openLoop;
   logic               fwdDriveRelay, reverseDriveRelay, tuneAbort;
   logic               profileHold, profileHoldLamp, sensorOpen, leadOpen;
   logic               tableExceeded;
   logic signed [15:0] rawValue, rangeMin, rangeMax, zeroLevelValue;
   logic signed [15:0] processValue, activeSetpoint, tuneSetpoint;
   logic        [15:0] regWdata, regRdata, d;
   logic        [3:0]  regAddr;
   pvam_input_t        inputType;
   pvam_brk_t          brkStrategy;
   int n_fail = 0, check_count = 0, seed = 45235;
   int sp = 100, asp, band, win, v, pv, nf, ns;

   // ------------------------------------------------------------
   // Design and sensor model
   // ------------------------------------------------------------
   pvam_monitor #(.FLASH_DIV(4)) DUT (.clk, .rst, .rawValue, .sensorOpen,
      .leadOpen, .tableExceeded, .inputType, .rangeMin, .rangeMax,
      .zeroLevelValue, .brkStrategy, .auxModeEn, .auxSelect, .adjustEn,
      .tuningRunning, .profileRunning, .loopRaise, .loopLower, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .processValue, .activeSetpoint,
      .tuneSetpoint, .errorFlash, .sensorOpenMessage, .underRange,
      .overRange, .openSensor, .alarm, .fwdDriveRelay, .reverseDriveRelay,
      .openLoop, .tuneAbort, .profileHold, .profileHoldLamp, .irq);
   pvam_front_end FE (.clk, .rawValue, .sensorOpen, .leadOpen,
      .tableExceeded);

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input int dv);
      @(posedge clk);
      regAddr <= a;
      regWdata <= 16'(dv);
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // Counts high cycles of both blink outputs over 16 cycles
   task automatic blink;
      nf = 0;
      ns = 0;
      repeat (16) begin
         step(1);
         nf += int'(errorFlash);
         ns += int'(sensorOpenMessage);
      end
   endtask : blink

   // Reference alarm; type 5 stands for a negative deviation band
   function automatic int exp_alm(input int t, input int p);
      case (t)
         1: return int'(p <= asp);
         2: return int'(p >= asp);
         3, 5: return int'(band >= 0 ? p > sp + band : p < sp + band);
         4: return int'(p > sp + win || p < sp - win);
         default: return 0;
      endcase
   endfunction : exp_alm

   task automatic close_out;
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // Watchdog: the whole sequence needs about 520 cycles
   initial begin
      #(25 * 20000);
      n_fail++;
      close_out();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rst, auxModeEn, auxSelect, adjustEn, tuningRunning} = 5'h11;
      {profileRunning, loopRaise, loopLower, regWr, regRd} = 5'h00;
      {regAddr, regWdata} = '0;
      inputType = IN_TC;
      brkStrategy = BRK_HOLD;
      rangeMin = -16'sd200;
      rangeMax = 16'sd1300;
      zeroLevelValue = -16'sd25;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      step(1);
      chk(activeSetpoint, SP_DEF);
      wr(4'h4, 500);
      rd(4'h4);
      chk(d, SP_DEF);
      // Alarm settings are locked as well as the setpoints
      wr(4'h1, 500);
      rd(4'h1);
      chk(d, ALM_SP_LOW_DEF);
      adjustEn <= 1'b1;
      wr(4'h4, sp);
      wr(4'h2, 2000);
      rd(4'h2);
      chk(d, DEV_BAND_MAX);
      wr(4'h3, 1);
      rd(4'h3);
      chk(d, WIN_BAND_MIN);
      rd(4'hf);
      chk(d, 16'h0000);
      wr(4'h0, 2);
      rd(4'h1);
      chk(d, ALM_SP_HIGH_DEF);
      wr(4'h0, 1);
      rd(4'h1);
      chk(d, ALM_SP_LOW_DEF);
      auxSelect <= 1'b1;
      wr(4'h5, 777);
      step(3);
      chk(activeSetpoint, 16'(sp));
      auxModeEn <= 1'b1;
      step(3);
      chk(activeSetpoint, 16'd777);
      chk(tuneSetpoint, 16'(sp));
      // Every alarm type against random, boundary and out-of-range values
      for (int t = 0; t < 6; t++) begin
         asp = t == 1 ? 300 : 900;
         band = t == 5 ? -50 : 50;
         win = 200;
         wr(4'h0, t == 5 ? 3 : t);
         wr(4'h1, asp);
         wr(4'h2, band);
         wr(4'h3, win);
         for (int k = 0; k < 8; k++) begin
            v = -200 + {$random(seed)} % 1501;
            if (k == 5) v = t == 4 ? sp + win : t > 2 ? sp + band : asp;
            if (k == 6) v = -260;
            if (k == 7) v = 1400;
            pv = v < -200 ? -200 : v > 1300 ? 1300 : v;
            tuningRunning <= 1'($random(seed));
            profileRunning <= 1'($random(seed));
            loopRaise <= 1'($random(seed));
            loopLower <= 1'($random(seed));
            FE.apply(v, 1'b0, 1'b0, 1'b0);
            step(5);
            chk(alarm, 16'(exp_alm(t, pv)));
            chk(underRange, v < -200);
            chk(overRange, v > 1300);
            chk(tuneAbort, v != pv && tuningRunning);
            chk(profileHold, v != pv && profileRunning);
            chk(profileHoldLamp, v != pv && profileRunning);
            if (v != pv) begin
               chk({fwdDriveRelay, reverseDriveRelay}, 2'b01);
            end else begin
               chk(processValue, 16'(v));
               // Normal control drives the relays when no error stands
               chk({fwdDriveRelay, reverseDriveRelay},
                   {loopRaise && !loopLower, loopLower && !loopRaise});
            end
         end
      end
      // Interrupt: raise, mask, clear by reading status
      wr(4'h7, 1);
      rd(4'h6);
      step(2);
      chk(irq, 1'b0);
      FE.apply(-300, 1'b0, 1'b0, 1'b0);
      step(5);
      chk(irq, 1'b1);
      blink();
      chk(nf > 0 && nf < 16, 1'b1);
      wr(4'h7, 0);
      step(2);
      chk(irq, 1'b0);
      FE.apply(500, 1'b0, 1'b0, 1'b0);
      step(5);
      rd(4'h6);
      chk(d[ST_UNDER], 1'b1);
      wr(4'h7, 1);
      step(2);
      chk(irq, 1'b0);
      blink();
      chk(nf, 0);
      // Open compensating lead is no error
      inputType <= IN_RTD;
      FE.apply(500, 1'b0, 1'b1, 1'b0);
      step(5);
      chk({underRange, overRange, openSensor}, 3'b000);
      // Open linear input reads as under-range at zero level
      inputType <= IN_LINEAR;
      FE.apply(500, 1'b1, 1'b0, 1'b0);
      step(5);
      chk({underRange, overRange, openLoop}, 3'b100);
      chk(processValue, zeroLevelValue);
      chk(reverseDriveRelay, 1'b1);
      // Temperature break under each valve strategy
      wr(4'h0, 2);
      for (int s = 0; s < 3; s++) begin
         inputType <= s == 2 ? IN_RTD : IN_TC;
         brkStrategy <= pvam_brk_t'(s);
         FE.apply(500, 1'b1, 1'b0, 1'b0);
         step(5);
         chk({overRange, openSensor, openLoop}, 3'b111);
         chk(reverseDriveRelay, s == 1);
         chk(fwdDriveRelay, s == 2);
         chk(alarm, 1'b1);
         FE.apply(0, 1'b0, 1'b0, 1'b0);
         step(5);
         chk(openLoop, 1'b0);
      end
      inputType <= IN_TC;
      FE.apply(1400, 1'b0, 1'b0, 1'b1);
      step(5);
      chk(openLoop, 1'b1);
      blink();
      chk(ns > 0 && ns < 16, 1'b1);
      close_out();
   end
endmodule : pvam_monitor_tb
